// *** hdl/pin_mux_pkg.sv ***
`include "pin_mux_regs.svh"

package pin_mux_pkg;

  // Latched strap selections, one bit per competing pin group.
  typedef struct packed {
    logic pci_sel;
    logic cell_sel;
    logic host32_sel;
    logic sp2_sel;
  } strap_vec_t;

endpackage

// *** hdl/pin_mux_regs.svh ***
`ifndef PIN_MUX_REGS_SVH
`define PIN_MUX_REGS_SVH

// ----------------------------------------------------------------------
// Pin group sizes
// ----------------------------------------------------------------------
`define SOFT_PIN_COUNT     10
`define GPIO_WIDTH         16
`define CLK_PIN_COUNT      3
`define PCI_GP_COUNT       7
`define HOST_PIN_COUNT     43
`define HOST_DATA_LOW_W    16
`define HOST_DATA_W        32
`define HALFWORD_PIN_IDX   38
`define SP1_PIN_COUNT      7
`define SP2_PIN_COUNT      3

// ----------------------------------------------------------------------
// Soft pin to GPIO bit mapping
// ----------------------------------------------------------------------
`define GP_QUARTER_BIT     1
`define GP_SIXTH_BIT       2
`define GP_SERIAL2_BIT     8
`define GP_PCI_FIRST_BIT   9
`define SOFT_SERIAL2_IDX   2

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define GPIO_DIR_INPUT     1'h0
`define PIN_OE_N_RESET     1'h1
`define PIN_OUT_RESET      1'h0

`endif

// *** hdl/shared_pin_function_select.sv ***
// Functional notes
// - Software-selected pins may switch function at any time.
// - Strap selections are caught during reset and frozen until next reset.
// - Each strap group is owned by exactly one peripheral after reset.
// - After reset clock pins carry clock functions; GPIO enables start cleared.
// - A soft pin is GPIO only when enabled; the direction bit only picks in or out.
// - Enabled GPIO: direction 0 is input, direction 1 is output.
// - GPIO 9 to 15 usable only while the PCI strap is 0.
// - Cell-bus strap 0 gives pins to serial port one, cell bus off.
// - PCI strap 0 gives shared pins to host port, PCI off.
// - Dedicated pins of a deselected cell bus or PCI are tied off.
// - Width strap 0 gives 16-bit host port, upper data undriven.
`include "pin_mux_regs.svh"
module shared_pin_function_select
  import pin_mux_pkg::*;
#(
  parameter int PCI_DED_W  = 8,
  parameter int CELL_DED_W = 8
) (
  // Clock and reset
  input  wire logic                         sys_clk_in,
  input  wire logic                         sys_rst_in,
  // Strap pins
  input  wire logic                         pci_strap_in,
  input  wire logic                         addr_strap_bit11_in,
  input  wire logic                         host_width_strap_in,
  input  wire logic                         serial2_strap_in,
  // Strap status
  output logic                              pci_selected_out,
  output logic                              cell_bus_selected_out,
  output logic                              host_port_32bit_out,
  output logic                              eeprom_selected_out,
  // GPIO controls
  input  wire logic [`GPIO_WIDTH-1:0]       gpio_pin_enable_bit_in,
  input  wire logic [`GPIO_WIDTH-1:0]       gpio_pin_direction_bit_in,
  input  wire logic [`GPIO_WIDTH-1:0]       gpio_dout_in,
  output logic      [`GPIO_WIDTH-1:0]       gpio_din_out,
  // Clock functions
  input  wire logic                         quarter_rate_clock_out_in,
  input  wire logic                         sixth_rate_clock_out_in,
  output logic                              serial2_clock_source_out,
  // PCI side of the GPIO pins
  input  wire logic [`PCI_GP_COUNT-1:0]     pci_gp_dout_in,
  input  wire logic [`PCI_GP_COUNT-1:0]     pci_gp_oe_n_in,
  output logic      [`PCI_GP_COUNT-1:0]     pci_gp_din_out,
  // Software-configured pins
  input  wire logic [`SOFT_PIN_COUNT-1:0]   soft_pin_in,
  output logic      [`SOFT_PIN_COUNT-1:0]   soft_pin_out,
  output logic      [`SOFT_PIN_COUNT-1:0]   soft_pin_oe_n_out,
  // Host port and PCI functions
  input  wire logic [`HOST_PIN_COUNT-1:0]   host_port_dout_in,
  input  wire logic [`HOST_PIN_COUNT-1:0]   host_port_oe_n_in,
  output logic      [`HOST_PIN_COUNT-1:0]   host_port_din_out,
  input  wire logic [`HOST_PIN_COUNT-1:0]   pci_bus_dout_in,
  input  wire logic [`HOST_PIN_COUNT-1:0]   pci_bus_oe_n_in,
  output logic      [`HOST_PIN_COUNT-1:0]   pci_bus_din_out,
  // Host/PCI pins
  input  wire logic [`HOST_PIN_COUNT-1:0]   hp_pin_in,
  output logic      [`HOST_PIN_COUNT-1:0]   hp_pin_out,
  output logic      [`HOST_PIN_COUNT-1:0]   hp_pin_oe_n_out,
  // Serial port one and cell bus functions
  input  wire logic [`SP1_PIN_COUNT-1:0]    serial_port_one_dout_in,
  input  wire logic [`SP1_PIN_COUNT-1:0]    serial_port_one_oe_n_in,
  output logic      [`SP1_PIN_COUNT-1:0]    serial_port_one_din_out,
  input  wire logic [`SP1_PIN_COUNT-1:0]    cell_bus_dout_in,
  input  wire logic [`SP1_PIN_COUNT-1:0]    cell_bus_oe_n_in,
  output logic      [`SP1_PIN_COUNT-1:0]    cell_bus_din_out,
  // Serial port one / cell bus pins
  input  wire logic [`SP1_PIN_COUNT-1:0]    sp1_pin_in,
  output logic      [`SP1_PIN_COUNT-1:0]    sp1_pin_out,
  output logic      [`SP1_PIN_COUNT-1:0]    sp1_pin_oe_n_out,
  // Serial port two and serial EEPROM functions
  input  wire logic [`SP2_PIN_COUNT-1:0]    serial_port_two_dout_in,
  input  wire logic [`SP2_PIN_COUNT-1:0]    serial_port_two_oe_n_in,
  output logic      [`SP2_PIN_COUNT-1:0]    serial_port_two_din_out,
  input  wire logic [`SP2_PIN_COUNT-1:0]    eeprom_dout_in,
  input  wire logic [`SP2_PIN_COUNT-1:0]    eeprom_oe_n_in,
  output logic      [`SP2_PIN_COUNT-1:0]    eeprom_din_out,
  // Serial port two / EEPROM pins
  input  wire logic [`SP2_PIN_COUNT-1:0]    sp2_pin_in,
  output logic      [`SP2_PIN_COUNT-1:0]    sp2_pin_out,
  output logic      [`SP2_PIN_COUNT-1:0]    sp2_pin_oe_n_out,
  // Dedicated PCI and cell bus pin enables
  input  wire logic [PCI_DED_W-1:0]         pci_ded_oe_n_in,
  output logic      [PCI_DED_W-1:0]         pci_ded_oe_n_out,
  input  wire logic [CELL_DED_W-1:0]        cell_ded_oe_n_in,
  output logic      [CELL_DED_W-1:0]        cell_ded_oe_n_out
);

  localparam int SW = `SOFT_PIN_COUNT;
  localparam int HW = `HOST_PIN_COUNT;
  localparam int S1 = `SP1_PIN_COUNT;
  localparam int S2 = `SP2_PIN_COUNT;
  localparam int PW = SW + HW + S1 + S2;

  typedef struct packed {
    logic [PW-1:0]          sync1;
    logic [PW-1:0]          sync2;
    logic [SW-1:0]          soft_out;
    logic [SW-1:0]          soft_oe_n;
    logic [HW-1:0]          hp_out;
    logic [HW-1:0]          hp_oe_n;
    logic [S1-1:0]          sp1_out;
    logic [S1-1:0]          sp1_oe_n;
    logic [S2-1:0]          sp2_out;
    logic [S2-1:0]          sp2_oe_n;
    logic [PCI_DED_W-1:0]   pci_ded_oe_n;
    logic [CELL_DED_W-1:0]  cell_ded_oe_n;
  } mux_state_t;

  mux_state_t state_q;
  mux_state_t state_d;
  strap_vec_t straps;

  strap_if strap_bus ();

  // ----------------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------------
  strap_latch u_strap_latch (
    .sys_clk_in          (sys_clk_in),
    .sys_rst_in          (sys_rst_in),
    .pci_strap_in        (pci_strap_in),
    .addr_strap_bit11_in (addr_strap_bit11_in),
    .host_width_strap_in (host_width_strap_in),
    .serial2_strap_in    (serial2_strap_in),
    .strap_out           (strap_bus.src)
  );

  assign straps = strap_bus.straps;

  // Maps a soft pin index to its GPIO bit number.
  function automatic int gp_bit(input int k);
    if (k < `SOFT_SERIAL2_IDX) begin
      return k + `GP_QUARTER_BIT;
    end else if (k == `SOFT_SERIAL2_IDX) begin
      return `GP_SERIAL2_BIT;
    end
    return k - `SOFT_SERIAL2_IDX - 1 + `GP_PCI_FIRST_BIT;
  endfunction

  // ----------------------------------------------------------------------
  // Pin selection
  // ----------------------------------------------------------------------
  // Every pin input goes through two flops before the muxes read it;
  // pin outputs are registered too, so each function sees a
  // two-cycle input and one-cycle output latency through the block.
  always_comb begin
    logic [SW-1:0] s_in;
    logic [HW-1:0] h_in;
    logic [S1-1:0] a_in;
    logic [S2-1:0] b_in;
    logic          gp_mode;
    logic          eeprom_sel;
    int            g;
    gp_mode       = 1'h0;
    eeprom_sel    = 1'h0;
    g             = 0;
    state_d       = state_q;
    state_d.sync1 = {soft_pin_in, hp_pin_in, sp1_pin_in, sp2_pin_in};
    state_d.sync2 = state_q.sync1;
    {s_in, h_in, a_in, b_in} = state_q.sync2;
    eeprom_sel = straps.pci_sel & ~straps.sp2_sel;
    gpio_din_out             = '0;
    serial2_clock_source_out = 1'h0;
    pci_gp_din_out           = '0;

    // Software pins follow the enable and direction bits live.
    for (int k = 0; k < SW; k++) begin
      g = gp_bit(k);
      gp_mode = gpio_pin_enable_bit_in[g];
      if (k > `SOFT_SERIAL2_IDX) begin
        gp_mode = gp_mode & ~straps.pci_sel;
      end
      if (gp_mode) begin
        state_d.soft_out[k]  = gpio_dout_in[g];
        state_d.soft_oe_n[k] = ~gpio_pin_direction_bit_in[g];
        gpio_din_out[g]      = s_in[k];
      end else if (k == 0) begin
        state_d.soft_out[k]  = quarter_rate_clock_out_in;
        state_d.soft_oe_n[k] = 1'h0;
      end else if (k == 1) begin
        state_d.soft_out[k]  = sixth_rate_clock_out_in;
        state_d.soft_oe_n[k] = 1'h0;
      end else if (k == `SOFT_SERIAL2_IDX) begin
        state_d.soft_out[k]      = `PIN_OUT_RESET;
        state_d.soft_oe_n[k]     = `PIN_OE_N_RESET;
        serial2_clock_source_out = s_in[k];
      end else if (straps.pci_sel) begin
        state_d.soft_out[k]  = pci_gp_dout_in[k-`SOFT_SERIAL2_IDX-1];
        state_d.soft_oe_n[k] = pci_gp_oe_n_in[k-`SOFT_SERIAL2_IDX-1];
        pci_gp_din_out[k-`SOFT_SERIAL2_IDX-1] = s_in[k];
      end else begin
        state_d.soft_out[k]  = `PIN_OUT_RESET;
        state_d.soft_oe_n[k] = `PIN_OE_N_RESET;
      end
    end

    // Host port or PCI owns the shared bus, never both.
    if (straps.pci_sel) begin
      state_d.hp_out    = pci_bus_dout_in;
      state_d.hp_oe_n   = pci_bus_oe_n_in;
      pci_bus_din_out   = h_in;
      host_port_din_out = '0;
    end else begin
      state_d.hp_out    = host_port_dout_in;
      state_d.hp_oe_n   = host_port_oe_n_in;
      host_port_din_out = h_in;
      pci_bus_din_out   = '0;
      if (!straps.host32_sel) begin
        state_d.hp_oe_n[`HOST_DATA_W-1:`HOST_DATA_LOW_W] = '1;
        host_port_din_out[`HOST_DATA_W-1:`HOST_DATA_LOW_W] = '0;
      end else begin
        host_port_din_out[`HALFWORD_PIN_IDX] = 1'h0;
      end
    end

    // Serial port one or the cell bus.
    if (straps.cell_sel) begin
      state_d.sp1_out         = cell_bus_dout_in;
      state_d.sp1_oe_n        = cell_bus_oe_n_in;
      cell_bus_din_out        = a_in;
      serial_port_one_din_out = '0;
    end else begin
      state_d.sp1_out         = serial_port_one_dout_in;
      state_d.sp1_oe_n        = serial_port_one_oe_n_in;
      serial_port_one_din_out = a_in;
      cell_bus_din_out        = '0;
    end

    // Serial port two or the serial EEPROM lines.
    if (eeprom_sel) begin
      state_d.sp2_out         = eeprom_dout_in;
      state_d.sp2_oe_n        = eeprom_oe_n_in;
      eeprom_din_out          = b_in;
      serial_port_two_din_out = '0;
    end else begin
      state_d.sp2_out         = serial_port_two_dout_in;
      state_d.sp2_oe_n        = serial_port_two_oe_n_in;
      serial_port_two_din_out = b_in;
      eeprom_din_out          = '0;
    end

    // Dedicated pins of a deselected peripheral stay undriven.
    state_d.pci_ded_oe_n  = straps.pci_sel ? pci_ded_oe_n_in : '1;
    state_d.cell_ded_oe_n = straps.cell_sel ? cell_ded_oe_n_in : '1;

    // Nothing drives a pin while reset is asserted.
    if (sys_rst_in) begin
      state_d.soft_out      = '0;
      state_d.soft_oe_n     = '1;
      state_d.hp_out        = '0;
      state_d.hp_oe_n       = '1;
      state_d.sp1_out       = '0;
      state_d.sp1_oe_n      = '1;
      state_d.sp2_out       = '0;
      state_d.sp2_oe_n      = '1;
      state_d.pci_ded_oe_n  = '1;
      state_d.cell_ded_oe_n = '1;
      state_d.sync1         = '0;
      state_d.sync2         = '0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    state_q <= state_d;
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign soft_pin_out          = state_q.soft_out;
  assign soft_pin_oe_n_out     = state_q.soft_oe_n;
  assign hp_pin_out            = state_q.hp_out;
  assign hp_pin_oe_n_out       = state_q.hp_oe_n;
  assign sp1_pin_out           = state_q.sp1_out;
  assign sp1_pin_oe_n_out      = state_q.sp1_oe_n;
  assign sp2_pin_out           = state_q.sp2_out;
  assign sp2_pin_oe_n_out      = state_q.sp2_oe_n;
  assign pci_ded_oe_n_out      = state_q.pci_ded_oe_n;
  assign cell_ded_oe_n_out     = state_q.cell_ded_oe_n;
  assign pci_selected_out      = straps.pci_sel;
  assign cell_bus_selected_out = straps.cell_sel;
  assign host_port_32bit_out   = straps.host32_sel;
  assign eeprom_selected_out   = straps.pci_sel & ~straps.sp2_sel;

endmodule

// *** hdl/strap_if.sv ***
// Carries the strap choices from the latch to the pin multiplexer.
interface strap_if;
  import pin_mux_pkg::*;

  strap_vec_t straps;

  modport src (output straps);
  modport dst (input  straps);
endinterface

// *** hdl/strap_latch.sv ***
module strap_latch
  import pin_mux_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       sys_rst_in,
  // Raw strap pins
  input  wire logic       pci_strap_in,
  input  wire logic       addr_strap_bit11_in,
  input  wire logic       host_width_strap_in,
  input  wire logic       serial2_strap_in,
  // Latched result
  strap_if.src            strap_out
);

  typedef struct packed {
    strap_vec_t sync1;
    strap_vec_t sync2;
    strap_vec_t held;
  } latch_state_t;

  latch_state_t state_q;
  latch_state_t state_d;

  // ----------------------------------------------------------------------
  // Synchroniser and reset-time capture
  // ----------------------------------------------------------------------
  // The synchroniser runs freely so that reset itself can sample the
  // straps; reset must therefore last at least three edges.
  always_comb begin
    state_d = state_q;
    state_d.sync1 = '{pci_sel:    pci_strap_in,
                      cell_sel:   addr_strap_bit11_in,
                      host32_sel: host_width_strap_in,
                      sp2_sel:    serial2_strap_in};
    state_d.sync2 = state_q.sync1;
    if (sys_rst_in) begin
      state_d.held = state_q.sync2;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    state_q <= state_d;
  end

  assign strap_out.straps = state_q.held;

endmodule

// *** test/board_model.sv ***
module board_model (
  // Strap choices and external pin levels
  input  wire logic [3:0]  strap_cfg_in,
  input  wire logic [62:0] ext_in,
  // Device pin drive
  input  wire logic [62:0] dev_out_in,
  input  wire logic [62:0] dev_oe_n_in,
  // Straps and resolved pins
  output logic             pci_strap_out,
  output logic             bit11_strap_out,
  output logic             width_strap_out,
  output logic             serial2_strap_out,
  output logic [62:0]      pin_out
);
  timeunit 1ns;
  timeprecision 1ns;

  // The resistors only hold a level; the bench keeps it steady in reset.
  assign pci_strap_out = strap_cfg_in[3];
  assign bit11_strap_out = strap_cfg_in[2];
  assign width_strap_out = strap_cfg_in[1];
  assign serial2_strap_out = strap_cfg_in[0];

  // External drivers only take undriven pins, and their level changes every
  // cycle, so a stale sample cannot pass for a fresh one.
  assign pin_out = (dev_oe_n_in & ext_in) | (~dev_oe_n_in & dev_out_in);
endmodule

// *** test/pin_mux_checker.sv ***
module pin_mux_checker #(
  parameter int PCI_DED_W  = 8,
  parameter int CELL_DED_W = 8
) (
  // Clock and reset
  input wire logic                  sys_clk_in,
  input wire logic                  sys_rst_in,
  // Strap status
  input wire logic                  pci_selected_out,
  input wire logic                  cell_bus_selected_out,
  input wire logic                  host_port_32bit_out,
  // Software pins
  input wire logic [15:0]           gpio_pin_enable_bit_in,
  input wire logic [15:0]           gpio_pin_direction_bit_in,
  input wire logic                  quarter_rate_clock_out_in,
  input wire logic [6:0]            pci_gp_oe_n_in,
  input wire logic [9:0]            soft_pin_out,
  input wire logic [9:0]            soft_pin_oe_n_out,
  // Strap selected pin groups
  input wire logic [42:0]           host_port_oe_n_in,
  input wire logic [42:0]           pci_bus_oe_n_in,
  input wire logic [42:0]           hp_pin_oe_n_out,
  input wire logic [6:0]            serial_port_one_oe_n_in,
  input wire logic [6:0]            cell_bus_oe_n_in,
  input wire logic [6:0]            sp1_pin_oe_n_out,
  input wire logic [PCI_DED_W-1:0]  pci_ded_oe_n_out,
  input wire logic [CELL_DED_W-1:0] cell_ded_oe_n_out
);
  timeunit 1ns;
  timeprecision 1ns;

  // All checks share one clock, and reset aborts every open attempt.
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);

  // Pin drive is registered, so each enable is compared one edge later.
  strap_hold_a: assert property (!$past(sys_rst_in) |->
    $stable({pci_selected_out, cell_bus_selected_out, host_port_32bit_out}))
    else $error("strap status moved outside reset");
  pci_drive_a: assert property (pci_selected_out |=>
    hp_pin_oe_n_out == $past(pci_bus_oe_n_in))
    else $error("shared pins not driven by the bus function");
  host_drive_a: assert property (!pci_selected_out |=>
    {hp_pin_oe_n_out[42:32], hp_pin_oe_n_out[15:0]} ==
    $past({host_port_oe_n_in[42:32], host_port_oe_n_in[15:0]}))
    else $error("shared pins not driven by the host port");
  upper_data_off_a: assert property (
    !pci_selected_out && !host_port_32bit_out |=> &hp_pin_oe_n_out[31:16])
    else $error("upper host data driven in narrow mode");
  cell_mux_a: assert property (1'b1 |=> sp1_pin_oe_n_out ==
    $past(cell_bus_selected_out ? cell_bus_oe_n_in : serial_port_one_oe_n_in))
    else $error("serial port one pins driven by the wrong owner");
  ded_tie_off_a: assert property (
    (pci_selected_out || &pci_ded_oe_n_out) &&
    (cell_bus_selected_out || &cell_ded_oe_n_out))
    else $error("dedicated pin of a deselected block driven");
  clock_func_a: assert property (!gpio_pin_enable_bit_in[1] |=>
    !soft_pin_oe_n_out[0] && soft_pin_out[0] == $past(quarter_rate_clock_out_in))
    else $error("quarter rate clock missing on its pin");
  gpio_dir_a: assert property (gpio_pin_enable_bit_in[1] |=>
    soft_pin_oe_n_out[0] == !$past(gpio_pin_direction_bit_in[1]))
    else $error("general purpose direction not applied");
  pci_gp_a: assert property (pci_selected_out |=>
    soft_pin_oe_n_out[9:3] == $past(pci_gp_oe_n_in))
    else $error("upper general purpose pins not owned by the bus");

  // The main strap modes must each be seen at least once.
  pci_mode_c: cover property (pci_selected_out);
  cell_mode_c: cover property (cell_bus_selected_out);
  wide_host_c: cover property (!pci_selected_out && host_port_32bit_out);
endmodule

bind shared_pin_function_select pin_mux_checker #(
  .PCI_DED_W (PCI_DED_W),
  .CELL_DED_W(CELL_DED_W)
) pin_mux_checker_inst (.*);

// *** test/test_shared_pin_function_select.sv ***
module test_shared_pin_function_select;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed {
    logic [15:0] en, dir, gdo;
    logic        qc, sc;
    logic [6:0]  pgd, pgo;
    logic [42:0] hd, ho, pd, po;
    logic [6:0]  s1d, s1o, cd, co;
    logic [2:0]  s2d, s2o, ed, eo;
    logic [7:0]  pded, cded;
    logic [62:0] xp;
    logic [28:0] pad;
  } stim_t;
  typedef struct packed {
    logic [62:0] o, e;
    logic [3:0]  s;
    logic [15:0] d;
  } exp_t;

  logic        sys_clk_in, sys_rst_in;
  logic [3:0]  scfg;
  logic [383:0] bits;
  stim_t       st;
  exp_t        q[$];
  exp_t        w;
  int          seed, num_errors, n_tests;
  wire  [62:0] pin_o, pin_e, pin_i;
  wire  [3:0]  sp, stat;
  wire  [42:0] hdin, pdin;
  wire  [15:0] gdin, ded;
  wire  [6:0]  pgdin, s1din, cdin;
  wire  [2:0]  s2din, edin;
  wire         s2clk;
  logic [62:0] p1, p2;
  logic [42:0] hx;
  logic [15:0] gx;
  logic        hit;
  int          gb;

  // Expected pin drive follows only from the straps and the stimulus.
  function automatic exp_t predict(stim_t t, logic [3:0] k);
    exp_t x;
    int   b;
    x = '0;
    x.s = {k[3], k[2], k[1], k[3] & ~k[0]};
    x.d = {k[3] ? t.pded : 8'hFF, k[2] ? t.cded : 8'hFF};
    x.o[62:20] = k[3] ? t.pd : t.hd;
    x.e[62:20] = k[3] ? t.po : t.ho;
    if (!k[3] && !k[1]) x.e[51:36] = 16'hFFFF;
    x.o[19:13] = k[2] ? t.cd : t.s1d;
    x.e[19:13] = k[2] ? t.co : t.s1o;
    x.o[12:10] = x.s[0] ? t.ed : t.s2d;
    x.e[12:10] = x.s[0] ? t.eo : t.s2o;
    for (int i = 0; i < 10; i++) begin
      b = (i < 2) ? i + 1 : i + 6;
      x.e[i] = 1'b1;
      if (i > 2 && k[3]) begin
        x.o[i] = t.pgd[i-3];
        x.e[i] = t.pgo[i-3];
      end else if (t.en[b]) begin
        x.o[i] = t.gdo[b];
        x.e[i] = ~t.dir[b];
      end else if (i < 2) begin
        x.o[i] = (i == 1) ? t.sc : t.qc;
        x.e[i] = 1'b0;
      end
    end
    return x;
  endfunction

  // Every comparison is counted; a mismatch is reported at once.
  task automatic check(string nm, logic [62:0] seen, logic [62:0] want);
    n_tests++;
    if (seen !== want) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, want, seen);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  board_model board_model_inst (
    .strap_cfg_in(scfg), .ext_in(st.xp), .dev_out_in(pin_o),
    .dev_oe_n_in(pin_e), .pci_strap_out(sp[3]), .bit11_strap_out(sp[2]),
    .width_strap_out(sp[1]), .serial2_strap_out(sp[0]), .pin_out(pin_i)
  );

  shared_pin_function_select shared_pin_function_select_inst (
    .sys_clk_in, .sys_rst_in,
    .pci_strap_in(sp[3]), .addr_strap_bit11_in(sp[2]),
    .host_width_strap_in(sp[1]), .serial2_strap_in(sp[0]),
    .pci_selected_out(stat[3]), .cell_bus_selected_out(stat[2]),
    .host_port_32bit_out(stat[1]), .eeprom_selected_out(stat[0]),
    .gpio_pin_enable_bit_in(st.en), .gpio_pin_direction_bit_in(st.dir),
    .gpio_dout_in(st.gdo), .gpio_din_out(gdin),
    .quarter_rate_clock_out_in(st.qc), .sixth_rate_clock_out_in(st.sc),
    .serial2_clock_source_out(s2clk), .pci_gp_dout_in(st.pgd),
    .pci_gp_oe_n_in(st.pgo), .pci_gp_din_out(pgdin),
    .soft_pin_in(pin_i[9:0]), .soft_pin_out(pin_o[9:0]),
    .soft_pin_oe_n_out(pin_e[9:0]), .host_port_dout_in(st.hd),
    .host_port_oe_n_in(st.ho), .host_port_din_out(hdin),
    .pci_bus_dout_in(st.pd), .pci_bus_oe_n_in(st.po),
    .pci_bus_din_out(pdin),
    .hp_pin_in(pin_i[62:20]), .hp_pin_out(pin_o[62:20]),
    .hp_pin_oe_n_out(pin_e[62:20]), .serial_port_one_dout_in(st.s1d),
    .serial_port_one_oe_n_in(st.s1o), .serial_port_one_din_out(s1din),
    .cell_bus_dout_in(st.cd), .cell_bus_oe_n_in(st.co),
    .cell_bus_din_out(cdin), .sp1_pin_in(pin_i[19:13]),
    .sp1_pin_out(pin_o[19:13]), .sp1_pin_oe_n_out(pin_e[19:13]),
    .serial_port_two_dout_in(st.s2d), .serial_port_two_oe_n_in(st.s2o),
    .serial_port_two_din_out(s2din), .eeprom_dout_in(st.ed),
    .eeprom_oe_n_in(st.eo), .eeprom_din_out(edin),
    .sp2_pin_in(pin_i[12:10]),
    .sp2_pin_out(pin_o[12:10]), .sp2_pin_oe_n_out(pin_e[12:10]),
    .pci_ded_oe_n_in(st.pded), .pci_ded_oe_n_out(ded[15:8]),
    .cell_ded_oe_n_in(st.cded), .cell_ded_oe_n_out(ded[7:0])
  );

  initial begin
    sys_clk_in = 1'b0;
    forever #25 sys_clk_in = ~sys_clk_in;
  end

  // A noted result belongs to the edge after its stimulus, so it is taken
  // off at that edge and compared once settled. Undriven bits of the output
  // value are masked, since only the enable says they are free. Pin levels
  // are kept two edges back, as inputs pass two flops cleared in reset.
  always @(posedge sys_clk_in) begin
    hit = q.size() > 0;
    if (hit) w = q.pop_front();
    #10;
    if (hit) begin
      check("pin_oe_n", pin_e, w.e);
      check("pin_out", pin_o | w.e, w.o | w.e);
      check("straps", {59'h0, stat}, {59'h0, w.s});
      check("ded_oe_n", {47'h0, ded}, {47'h0, w.d});
      hx = p2[62:20];
      if (w.s[1]) hx[38] = 1'b0;
      else hx[31:16] = 16'h0;
      check("host_din", hdin, w.s[3] ? 43'h0 : hx);
      check("pci_din", pdin, w.s[3] ? p2[62:20] : 43'h0);
      check("sp1_din", s1din, w.s[2] ? 7'h0 : p2[19:13]);
      check("cell_din", cdin, w.s[2] ? p2[19:13] : 7'h0);
      check("sp2_din", s2din, w.s[0] ? 3'h0 : p2[12:10]);
      check("eeprom_din", edin, w.s[0] ? p2[12:10] : 3'h0);
      gx = 16'h0;
      for (int i = 0; i < 10; i++) begin
        gb = (i < 2) ? i + 1 : i + 6;
        if (st.en[gb] && !(i > 2 && w.s[3])) gx[gb] = p2[i];
      end
      check("gpio_din", gdin, gx);
      check("pci_gp_din", pgdin, w.s[3] ? p2[9:3] : 7'h0);
      check("s2_clock", s2clk, !st.en[8] && p2[2]);
    end
    p2 = p1;
    p1 = sys_rst_in ? 63'h0 : pin_i;
  end

  // Every strap combination gets a 20 cycle reset, then random traffic
  // while the straps wander, which the latched choice must ignore.
  initial begin
    seed = 19;
    sys_rst_in = 1'b1;
    scfg = 4'h0;
    st = '0;
    for (int k = 0; k < 16; k++) begin
      @(posedge sys_clk_in);
      #1 sys_rst_in = 1'b1;
      scfg = k[3:0];
      st.xp = 63'h0;
      repeat (19) @(posedge sys_clk_in);
      for (int c = 0; c < 30; c++) begin
        @(posedge sys_clk_in);
        #1 sys_rst_in = 1'b0;
        for (int j = 0; j < 12; j++) bits[j*32 +: 32] = $random(seed);
        st = stim_t'(bits);
        if (c == 0) st.en = 16'h0000;
        scfg = st.pad[3:0];
        q.push_back(predict(st, k[3:0]));
      end
      $display("strap set %0d done", k);
    end
    repeat (2) @(posedge sys_clk_in);
    final_report();
  end
endmodule
